// ### inc/bgsc_pkg.sv
// package for the global slew and transient-boost configuration bank
// shared by the device end and the host end; no clocking assumptions
package bgsc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // register addresses
  localparam logic [7:0] ADDR_START_STOP = 8'h33;
  localparam logic [7:0] ADDR_VOLT_CHANGE = 8'h34;
  localparam logic [7:0] ADDR_BOOST = 8'h35;
  localparam logic [7:0] ADDR_RSVD_FIRST = 8'h36;
  // reset values
  localparam logic [7:0] RST_START_STOP = 8'h24;
  localparam logic [7:0] RST_VOLT_CHANGE = 8'h24;
  localparam logic [7:0] RST_BOOST = 8'h5f;
  // field positions
  localparam int unsigned HI_SEL_LSB = 4;
  localparam int unsigned LO_SEL_LSB = 0;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned POS_BOOST_BIT = 1;
  localparam int unsigned NEG_BOOST_BIT = 0;
  // writable masks; other bits hold their reset pattern
  localparam logic [7:0] MASK_RATE = 8'h77;
  localparam logic [7:0] MASK_BOOST = 8'h03;
  // rate select codes, from 1.25 mV/us doubled per code up to 40 mV/us; codes 6 and 7 both give 60 mV/us
  typedef enum logic [2:0] {
    BGSC_RATE_1P25 = 3'h0,
    BGSC_RATE_2P5 = 3'h1,
    BGSC_RATE_5 = 3'h2,
    BGSC_RATE_10 = 3'h3,
    BGSC_RATE_20 = 3'h4,
    BGSC_RATE_40 = 3'h5,
    BGSC_RATE_60 = 3'h6,
    BGSC_RATE_60B = 3'h7
  } bgsc_rate_t;
  // rate in units of 0.25 mV/us for codes 0..7
  localparam logic [7:0] RATE_QMV [8] = '{8'd5, 8'd10, 8'd20, 8'd40, 8'd80,
                                          8'd160, 8'd240, 8'd240};
endpackage

// ### inc/bgsc_if.sv
// register access link between host end and device end
// one clock domain; the host drives strobes, the device answers next cycle
`timescale 1ns/1ps
`default_nettype none
interface bgsc_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic rvalid;
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
endinterface
`default_nettype wire

// ### design/bgsc_dev.sv
// device end: global slew-rate and transient-boost configuration bank
// assumes one clock, synchronous active-low reset, host keeps one strobe at a time
// Contract
// - shutdown rate select at first register 6:4
// - softstart rate select bits 2:0, reset 100
// - rampdown rate select second register 6:4, reset 010
// - rampup rate select bits 2:0, reset 100
// - positive boost enable bit 1, reset set
// - negative boost enable bit 0, reset set
// - first register at 0x33, RW, reset 0x24
// - second register at 0x34, RW, reset 0x24
// - third register at 0x35, reset 0x5f
// - host avoids addresses 0x36 through 0xff
`timescale 1ns/1ps
`default_nettype none
module bgsc_dev (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register link
  bgsc_if.dev bus,
  // configuration outputs
  output logic [2:0] shutdown_rate_sel_o,
  output logic [2:0] softstart_rate_sel_o,
  output logic [2:0] rampdown_rate_sel_o,
  output logic [2:0] rampup_rate_sel_o,
  output logic [7:0] shutdown_rate_qmv_o,
  output logic [7:0] softstart_rate_qmv_o,
  output logic [7:0] rampdown_rate_qmv_o,
  output logic [7:0] rampup_rate_qmv_o,
  output logic positive_transient_boost_en_o,
  output logic negative_transient_boost_en_o
);
  import bgsc_pkg::*;

  // the bank holds three byte registers on a plain address and strobe link;
  // a write lands at the edge that samples its strobe, a read answers one
  // cycle later with data beside a valid pulse; nothing here can stall the
  // host, so there is no ready signal and strobes may follow in any order

  // reset is synchronous and active low; while it is held the registers show
  // their power-on values and the read answer is zero, while the decoded
  // rates read zero and become valid one edge after release

  // a write sampled at edge n shows on the selects after edge n and on the
  // decoded rates after edge n+1; a read sampled at edge n answers until
  // edge n+1, where the host takes it

  // register state, current and next
  logic [7:0] start_stop_ramp_rate_cfg_q;
  logic [7:0] start_stop_ramp_rate_cfg_d;
  logic [7:0] voltage_change_ramp_rate_cfg_q;
  logic [7:0] voltage_change_ramp_rate_cfg_d;
  logic [7:0] transient_boost_cfg_q;
  logic [7:0] transient_boost_cfg_d;

  // read answer, current and next
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // rate selects in the order shutdown, soft-start, ramp-down, ramp-up, and
  // their registered decode in steps of 0.25 mV/us
  wire [2:0] rate_sel [4];
  wire [7:0] rate_qmv [4];

  // boost enables as held in the third register
  wire pos_boost = transient_boost_cfg_q[POS_BOOST_BIT];
  wire neg_boost = transient_boost_cfg_q[NEG_BOOST_BIT];

  // address decode: a full eight-bit compare per register, so the bank has
  // no aliases elsewhere in the map
  wire hit_ss = bus.addr == ADDR_START_STOP;
  wire hit_vc = bus.addr == ADDR_VOLT_CHANGE;
  wire hit_tb = bus.addr == ADDR_BOOST;

  // write enables; a write to any other address finds no enable and is lost
  // a write and a read never share a cycle on this link, so no priority is needed
  wire wr_ss = bus.wr && hit_ss;
  wire wr_vc = bus.wr && hit_vc;
  wire wr_tb = bus.wr && hit_tb;

  // write values: writable fields from the host, reserved bits from their
  // reset pattern, so a careless write cannot disturb them; the cost is that
  // software can never use those bits as scratch storage
  wire [7:0] ss_wr_val = (bus.wdata & MASK_RATE) | (RST_START_STOP & ~MASK_RATE);
  wire [7:0] vc_wr_val = (bus.wdata & MASK_RATE) | (RST_VOLT_CHANGE & ~MASK_RATE);
  wire [7:0] tb_wr_val = (bus.wdata & MASK_BOOST) | (RST_BOOST & ~MASK_BOOST);

  // next register values: hold unless this register's enable is up
  assign start_stop_ramp_rate_cfg_d = wr_ss ? ss_wr_val :
      start_stop_ramp_rate_cfg_q;
  assign voltage_change_ramp_rate_cfg_d = wr_vc ? vc_wr_val :
      voltage_change_ramp_rate_cfg_q;
  assign transient_boost_cfg_d = wr_tb ? tb_wr_val :
      transient_boost_cfg_q;

  // read terms, one per register, merged by a plain or; an address that
  // matches nothing leaves every term at zero, and since the compares are
  // exclusive the or never mixes two registers
  wire [7:0] rd_ss = hit_ss ? start_stop_ramp_rate_cfg_q : 8'h00;
  wire [7:0] rd_vc = hit_vc ? voltage_change_ramp_rate_cfg_q : 8'h00;
  wire [7:0] rd_tb = hit_tb ? transient_boost_cfg_q : 8'h00;
  // unmapped addresses, including 0x36 and up, read back zero
  wire [7:0] rd_sel = rd_ss | rd_vc | rd_tb;

  // the answer is zero outside a read so the link never shows stale data
  assign rdata_d = bus.rd ? rd_sel : 8'h00;
  assign rvalid_d = bus.rd;

  // first register: shutdown and soft-start rate selects
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      start_stop_ramp_rate_cfg_q <= RST_START_STOP;
    end else begin
      start_stop_ramp_rate_cfg_q <= start_stop_ramp_rate_cfg_d;
    end
  end

  // second register: ramp-down and ramp-up rate selects
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      voltage_change_ramp_rate_cfg_q <= RST_VOLT_CHANGE;
    end else begin
      voltage_change_ramp_rate_cfg_q <= voltage_change_ramp_rate_cfg_d;
    end
  end

  // third register: the two boost enables over a fixed reserved pattern
  // only two bits are live; the other six are constants in practice and
  // fold away in synthesis
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      transient_boost_cfg_q <= RST_BOOST;
    end else begin
      transient_boost_cfg_q <= transient_boost_cfg_d;
    end
  end

  // read data: stands for one cycle after the read strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // read valid: one pulse per read strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // field extraction at the package's field positions
  assign rate_sel[0] = start_stop_ramp_rate_cfg_q[HI_SEL_LSB +: SEL_W];
  assign rate_sel[1] = start_stop_ramp_rate_cfg_q[LO_SEL_LSB +: SEL_W];
  assign rate_sel[2] = voltage_change_ramp_rate_cfg_q[HI_SEL_LSB +: SEL_W];
  assign rate_sel[3] = voltage_change_ramp_rate_cfg_q[LO_SEL_LSB +: SEL_W];

  // rate codes double the slew from 1.25 mV/us up to 40 mV/us; the two top
  // codes both give 60 mV/us, so the table repeats its last entry
  // the decode lags the select by one cycle, which only matters to a consumer
  // that compares the two in the cycle right after a write
  // each decode keeps its own flop so no array element has two drivers
  for (genvar f = 0; f < 4; f = f + 1) begin : g_rate
    logic [7:0] qmv_q;
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        qmv_q <= 8'h00;
      end else begin
        qmv_q <= RATE_QMV[rate_sel[f]];
      end
    end
    assign rate_qmv[f] = qmv_q;
  end

  // link answer
  assign bus.rdata = rdata_q;
  assign bus.rvalid = rvalid_q;

  // rate selects, straight from the register flops
  assign shutdown_rate_sel_o = rate_sel[0];
  assign softstart_rate_sel_o = rate_sel[1];
  assign rampdown_rate_sel_o = rate_sel[2];
  assign rampup_rate_sel_o = rate_sel[3];

  // decoded rates, straight from the decode flops
  assign shutdown_rate_qmv_o = rate_qmv[0];
  assign softstart_rate_qmv_o = rate_qmv[1];
  assign rampdown_rate_qmv_o = rate_qmv[2];
  assign rampup_rate_qmv_o = rate_qmv[3];

  // boost enables, straight from the register flops
  assign positive_transient_boost_en_o = pos_boost;
  assign negative_transient_boost_en_o = neg_boost;
endmodule
`default_nettype wire

// ### design/bgsc_host.sv
// host end: forwards software register accesses onto the link
// assumes software port strobes are one cycle and never both at once
`timescale 1ns/1ps
`default_nettype none
module bgsc_host (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // software port
  input wire logic [7:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o,
  output logic sw_rsvd_err_o,
  // register link
  bgsc_if.host bus
);
  import bgsc_pkg::*;

  logic [7:0] addr_q, wdata_q, rdata_q;
  logic wr_q, rd_q, err_q;
  // an access to the reserved area never raises a strobe on the link
  wire in_rsvd = sw_addr_i >= ADDR_RSVD_FIRST;
  // keep the reserved pattern of the boost register on every write
  wire [7:0] wdata_fix = (sw_addr_i == ADDR_BOOST) ?
      ((sw_wdata_i & MASK_BOOST) | (RST_BOOST & ~MASK_BOOST)) : sw_wdata_i;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      addr_q <= sw_addr_i;
      wdata_q <= wdata_fix;
      wr_q <= sw_wr_i && !in_rsvd;
      rd_q <= sw_rd_i && !in_rsvd;
      err_q <= (sw_wr_i || sw_rd_i) && in_rsvd;
      rdata_q <= bus.rvalid ? bus.rdata : 8'h00;
    end
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
  assign sw_rdata_o = rdata_q;
  assign sw_rsvd_err_o = err_q;
endmodule
`default_nettype wire

// ### test/bgsc_props.sv
// checker for the register link between host end and device end
// assumes one clock and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module bgsc_props (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // link
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire mapped = addr >= 8'h33 && addr <= 8'h35;
  sequence s_wr_rd;
    wr && addr == 8'h33 ##1 rd && addr == 8'h33;
  endsequence
  a_read_answer: assert property (rd |=> rvalid) else $error("read unanswered");
  a_no_stray: assert property (!rd |=> !rvalid && rdata == 8'h00) else $error("stray data");
  a_one_strobe: assert property (!(wr && rd)) else $error("two strobes");
  a_cfg1_rsvd: assert property (rd && addr == 8'h33 |=> rdata[7] == 1'b0 && rdata[3] == 1'b0)
    else $error("cfg1 reserved bit set");
  a_cfg2_rsvd: assert property (rd && addr == 8'h34 |=> rdata[7] == 1'b0 && rdata[3] == 1'b0)
    else $error("cfg2 reserved bit set");
  a_boost_pattern: assert property (rd && addr == 8'h35 |=> rdata[7:2] == 6'h17)
    else $error("boost pattern lost");
  a_unmapped_zero: assert property (rd && !mapped |=> rdata == 8'h00) else $error("unmapped data");
  a_write_readback: assert property (s_wr_rd |=> rdata == ($past(wdata, 2) & 8'h77))
    else $error("readback differs");
endmodule
`default_nettype wire

// ### test/test_buck_global_slew_config.sv
// bench: host end and device end joined by the link, checker beside it
// assumes a 100 MHz clock and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module test_buck_global_slew_config;
  import bgsc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] sw_addr_i = 8'h00;
  logic [7:0] sw_wdata_i = 8'h00;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [7:0] sw_rdata_o, q0, q1, q2, q3;
  logic sw_rsvd_err_o, pb, nb;
  logic [2:0] sd, ss, rdn, ru;
  logic [7:0] shadow [3];
  int bad_count = 0;
  int comparisons = 0;
  int seed = 80;
  bgsc_if link ();
  bgsc_dev i_bgsc_dev (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(link),
    .shutdown_rate_sel_o(sd), .softstart_rate_sel_o(ss), .rampdown_rate_sel_o(rdn),
    .rampup_rate_sel_o(ru), .shutdown_rate_qmv_o(q0), .softstart_rate_qmv_o(q1),
    .rampdown_rate_qmv_o(q2), .rampup_rate_qmv_o(q3),
    .positive_transient_boost_en_o(pb), .negative_transient_boost_en_o(nb));
  bgsc_host i_bgsc_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
    .sw_rsvd_err_o(sw_rsvd_err_o), .bus(link));
  bgsc_props i_bgsc_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .rvalid(link.rvalid));
  always #5 ref_clk_i = ~ref_clk_i;
  function automatic logic [7:0] qmv(input logic [2:0] c);
    return (c[2] & c[1]) ? 8'd240 : 8'd5 << c;
  endfunction
  function automatic logic [7:0] expect_rd(input logic [7:0] a);
    return (a >= 8'h33 && a <= 8'h35) ? shadow[int'(a) - 'h33] : 8'h00;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    sw_wr_i <= w;
    sw_rd_i <= !w;
    sw_addr_i <= a;
    sw_wdata_i <= d;
    @(posedge ref_clk_i);
    sw_wr_i <= 1'b0;
    sw_rd_i <= 1'b0;
    #1 check(sw_rsvd_err_o, a >= ADDR_RSVD_FIRST);
    // reserved bits keep their reset pattern whatever is written
    if (w && a >= ADDR_START_STOP && a <= ADDR_BOOST)
      shadow[int'(a) - 'h33] = (a == ADDR_BOOST) ? (d & MASK_BOOST) | 8'h5c : d & MASK_RATE;
    repeat (2) @(posedge ref_clk_i);
    #1 if (!w) check(sw_rdata_o, expect_rd(a));
    check({sd, ss, rdn, ru}, {shadow[0][6:4], shadow[0][2:0], shadow[1][6:4], shadow[1][2:0]});
    check({q0, q1, q2, q3}, {qmv(shadow[0][6:4]), qmv(shadow[0][2:0]), qmv(shadow[1][6:4]), qmv(shadow[1][2:0])});
    check({pb, nb}, shadow[2][1:0]);
  endtask
  initial begin
    shadow = '{RST_START_STOP, RST_VOLT_CHANGE, RST_BOOST};
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int a = 'h32; a <= 'h37; a++) xfer(1'b0, 8'(a), 8'h00);
    xfer(1'b1, ADDR_BOOST, 8'h00);
    xfer(1'b1, 8'hff, 8'hff);
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, ADDR_START_STOP, {1'b1, 3'(c), 1'b1, 3'(7 - c)});
      xfer(1'b1, ADDR_VOLT_CHANGE, {1'b1, 3'(7 - c), 1'b1, 3'(c)});
    end
    // write then read with no gap on the link
    @(posedge ref_clk_i);
    sw_wr_i <= 1'b1;
    sw_addr_i <= ADDR_START_STOP;
    sw_wdata_i <= 8'hff;
    @(posedge ref_clk_i);
    sw_wr_i <= 1'b0;
    sw_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    sw_rd_i <= 1'b0;
    shadow[0] = 8'h77;
    repeat (2) @(posedge ref_clk_i);
    #1 check(sw_rdata_o, 8'h77);
    repeat (60) xfer(1'($random(seed)), 8'h30 + 8'($random(seed) & 7), 8'($random(seed)));
    print_verdict;
  end
  initial begin
    #20000;
    bad_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
